/* bit_carry_ops_and_branch_eval.sv */
`timescale 1ns/1ps
`default_nettype none

module bit_carry_ops_and_branch_eval (
	input wire logic clk,
	input wire logic resetn,
	input wire exec_pkg::instr_t instr,
	input wire logic instr_valid,
	output logic instr_ready,
	output exec_pkg::flags_t flags,
	output logic [23:0] pc,
	output logic [23:0] sp,
	output logic [7:0] result_byte,
	output logic result_valid,
	output exec_pkg::mem_req_t mem,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);

	// ---------------------------------------------------------------
	// Bit selection and condition decode
	// ---------------------------------------------------------------
	typedef enum {st_idle, st_push, st_pop} state_t;
	state_t state;

	wire logic sel_bit = instr.operand[instr.bit_no];
	wire logic nxv = flags.n ^ flags.v;
	logic cond_true;

	always_comb begin
		case (instr.cond)
			exec_pkg::branch_always: cond_true = 1'b1;
			exec_pkg::branch_never: cond_true = 1'b0;
			exec_pkg::branch_unsigned_higher: cond_true = ~(flags.c | flags.z);
			exec_pkg::branch_lower_or_same: cond_true = flags.c | flags.z;
			exec_pkg::branch_carry_clear: cond_true = ~flags.c;
			exec_pkg::branch_carry_set: cond_true = flags.c;
			exec_pkg::branch_not_equal: cond_true = ~flags.z;
			exec_pkg::branch_equal: cond_true = flags.z;
			exec_pkg::branch_overflow_clear: cond_true = ~flags.v;
			exec_pkg::branch_overflow_set: cond_true = flags.v;
			exec_pkg::branch_plus: cond_true = ~flags.n;
			exec_pkg::branch_minus: cond_true = flags.n;
			exec_pkg::branch_signed_ge: cond_true = ~nxv;
			exec_pkg::branch_signed_lt: cond_true = nxv;
			exec_pkg::branch_signed_gt: cond_true = ~(flags.z | nxv);
			exec_pkg::branch_signed_le: cond_true = flags.z | nxv;
			default: cond_true = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// Carry result and store byte
	// ---------------------------------------------------------------
	logic next_c;
	logic store_bit;
	logic is_store;

	always_comb begin
		next_c = flags.c;
		store_bit = flags.c;
		is_store = 1'b0;
		case (instr.op)
			exec_pkg::bit_or_carry: next_c = flags.c | sel_bit;
			exec_pkg::inverted_bit_or_carry: next_c = flags.c | ~sel_bit;
			exec_pkg::bit_xor_carry: next_c = flags.c ^ sel_bit;
			exec_pkg::inverted_bit_xor_carry: next_c = flags.c ^ ~sel_bit;
			exec_pkg::bit_load_carry: next_c = sel_bit;
			exec_pkg::inverted_bit_load_carry: next_c = ~sel_bit;
			exec_pkg::bit_store_carry: begin
				is_store = 1'b1;
			end
			exec_pkg::inverted_bit_store_carry: begin
				is_store = 1'b1;
				store_bit = ~flags.c;
			end
			default: next_c = flags.c;
		endcase
	end

	logic [7:0] stored_byte;

	always_comb begin
		stored_byte = instr.operand;
		stored_byte[instr.bit_no] = store_bit;
	end

	// ---------------------------------------------------------------
	// Flow control
	// ---------------------------------------------------------------
	wire logic is_call = (instr.op == exec_pkg::call_relative) || (instr.op == exec_pkg::call_absolute);
	wire logic is_ret = instr.op == exec_pkg::return_sub;
	wire logic idle = state == st_idle;
	wire logic take = instr_valid && idle;
	wire logic [23:0] sp_dec = sp - 24'(exec_pkg::RET_BYTES);
	wire logic [23:0] sp_inc = sp + 24'(exec_pkg::RET_BYTES);

	// Calls and returns stall until the stack access is acknowledged
	assign instr_ready = idle;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= st_idle;
			flags <= exec_pkg::CCR_RESET;
			pc <= exec_pkg::PC_RESET;
			sp <= exec_pkg::SP_RESET;
			result_byte <= 8'h00;
			result_valid <= 1'b0;
			mem <= '0;
		end else begin
			result_valid <= 1'b0;
			case (state)
				st_idle: begin
					if (take) begin
						// Flow ops only touch C through next_c, which keeps C for them
						flags.c <= next_c;
						result_byte <= stored_byte;
						result_valid <= is_store;
						pc <= instr.next_pc;
						if (instr.op == exec_pkg::cond_branch && cond_true) begin
							pc <= instr.target;
						end
						if (instr.op == exec_pkg::jump_absolute) begin
							pc <= instr.target;
						end
						if (is_call) begin
							mem <= '{req: 1'b1, we: 1'b1, addr: sp_dec, wdata: {8'h00, instr.next_pc}};
							sp <= sp_dec;
							pc <= instr.target;
							state <= st_push;
						end
						if (is_ret) begin
							mem <= '{req: 1'b1, we: 1'b0, addr: sp, wdata: 32'h0};
							state <= st_pop;
						end
					end
				end
				st_push: begin
					if (mem_ack) begin
						mem <= '0;
						state <= st_idle;
					end
				end
				st_pop: begin
					if (mem_ack) begin
						mem <= '0;
						pc <= mem_rdata[23:0];
						sp <= sp_inc;
						state <= st_idle;
					end
				end
				default: state <= st_idle;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence take_op(exec_pkg::op_t o);
		take && instr.op == o;
	endsequence

	or_carry_a: assert property (@(posedge clk) disable iff (!resetn)
		take_op(exec_pkg::bit_or_carry) |=> flags.c == ($past(flags.c) | $past(sel_bit)))
		else $error("or carry wrong");
	xor_carry_a: assert property (@(posedge clk) disable iff (!resetn)
		take_op(exec_pkg::bit_xor_carry) |=> flags.c == ($past(flags.c) ^ $past(sel_bit)))
		else $error("xor carry wrong");
	inv_load_a: assert property (@(posedge clk) disable iff (!resetn)
		take_op(exec_pkg::inverted_bit_load_carry) |=> flags.c == !$past(sel_bit))
		else $error("inverted load wrong");
	store_byte_a: assert property (@(posedge clk) disable iff (!resetn)
		take_op(exec_pkg::bit_store_carry) |=> result_valid && result_byte[$past(instr.bit_no)] == $past(flags.c))
		else $error("store bit wrong");
	branch_taken_a: assert property (@(posedge clk) disable iff (!resetn)
		take_op(exec_pkg::cond_branch) |=> pc == ($past(cond_true) ? $past(instr.target) : $past(instr.next_pc)))
		else $error("branch pc wrong");
	signed_gt_a: assert property (@(posedge clk) disable iff (!resetn)
		instr.cond == exec_pkg::branch_signed_gt |-> cond_true == !(flags.z || (flags.n != flags.v)))
		else $error("gt condition wrong");
	call_push_a: assert property (@(posedge clk) disable iff (!resetn)
		take && is_call |=> mem.req && mem.we && mem.wdata[23:0] == $past(instr.next_pc) && sp == mem.addr)
		else $error("call push wrong");
	flow_flags_a: assert property (@(posedge clk) disable iff (!resetn)
		take && (is_call || is_ret || instr.op == exec_pkg::cond_branch) |=> $stable(flags))
		else $error("flags changed by flow op");
	ret_pop_a: assert property (@(posedge clk) disable iff (!resetn)
		state == st_pop && mem_ack |=> pc == $past(mem_rdata[23:0]) && idle)
		else $error("return pc wrong");

	// ---------------------------------------------------------------
	// Carry operation checks
	// ---------------------------------------------------------------
	inv_or_carry_a: assert property (@(posedge clk) disable iff (!resetn)
		take_op(exec_pkg::inverted_bit_or_carry) |=> flags.c == ($past(flags.c) | !$past(sel_bit)))
		else $error("inverted or carry wrong");
	inv_xor_carry_a: assert property (@(posedge clk) disable iff (!resetn)
		take_op(exec_pkg::inverted_bit_xor_carry) |=> flags.c == ($past(flags.c) ^ !$past(sel_bit)))
		else $error("inverted xor carry wrong");
	load_carry_a: assert property (@(posedge clk) disable iff (!resetn)
		take_op(exec_pkg::bit_load_carry) |=> flags.c == $past(sel_bit))
		else $error("bit load wrong");
	inv_store_byte_a: assert property (@(posedge clk) disable iff (!resetn)
		take_op(exec_pkg::inverted_bit_store_carry) |=> result_valid && result_byte[$past(instr.bit_no)] == !$past(flags.c))
		else $error("inverted store bit wrong");
	// Only the selected bit may differ from the operand
	store_others_a: assert property (@(posedge clk) disable iff (!resetn)
		take && is_store |=> ((result_byte ^ $past(instr.operand)) & ~(8'h01 << $past(instr.bit_no))) == 8'h00)
		else $error("store touched other bits");
	store_carry_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		take && is_store |=> flags.c == $past(flags.c))
		else $error("store changed carry");
	store_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
		result_valid |-> $past(take && is_store))
		else $error("result pulse without store");
	no_store_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
		take && !is_store |=> !result_valid)
		else $error("result pulse on non store");
	bit_pick_a: assert property (@(posedge clk) disable iff (!resetn)
		((instr.operand >> instr.bit_no) & 8'h01) == {7'h00, sel_bit})
		else $error("selected bit wrong");

	// ---------------------------------------------------------------
	// Branch checks
	// ---------------------------------------------------------------
	always_taken_a: assert property (@(posedge clk) disable iff (!resetn)
		instr.cond == exec_pkg::branch_always |-> cond_true)
		else $error("always branch not taken");
	never_taken_a: assert property (@(posedge clk) disable iff (!resetn)
		instr.cond == exec_pkg::branch_never |-> !cond_true)
		else $error("never branch taken");
	seq_pc_a: assert property (@(posedge clk) disable iff (!resetn)
		take && !is_call && !is_ret && instr.op != exec_pkg::jump_absolute
		&& !(instr.op == exec_pkg::cond_branch && cond_true) |=> pc == $past(instr.next_pc))
		else $error("sequential pc wrong");
	higher_cond_a: assert property (@(posedge clk) disable iff (!resetn)
		instr.cond == exec_pkg::branch_unsigned_higher |-> cond_true == !(flags.c || flags.z))
		else $error("higher condition wrong");
	same_cond_a: assert property (@(posedge clk) disable iff (!resetn)
		instr.cond == exec_pkg::branch_lower_or_same |-> cond_true == (flags.c || flags.z))
		else $error("lower or same condition wrong");
	carry_cond_a: assert property (@(posedge clk) disable iff (!resetn)
		instr.cond == exec_pkg::branch_carry_clear |-> cond_true == !flags.c)
		else $error("carry clear condition wrong");
	equal_cond_a: assert property (@(posedge clk) disable iff (!resetn)
		instr.cond == exec_pkg::branch_equal |-> cond_true == flags.z)
		else $error("equal condition wrong");
	minus_cond_a: assert property (@(posedge clk) disable iff (!resetn)
		instr.cond == exec_pkg::branch_minus |-> cond_true == flags.n)
		else $error("minus condition wrong");
	overflow_cond_a: assert property (@(posedge clk) disable iff (!resetn)
		instr.cond == exec_pkg::branch_overflow_set |-> cond_true == flags.v)
		else $error("overflow condition wrong");
	signed_ge_a: assert property (@(posedge clk) disable iff (!resetn)
		instr.cond == exec_pkg::branch_signed_ge |-> cond_true == (flags.n == flags.v))
		else $error("ge condition wrong");
	signed_le_a: assert property (@(posedge clk) disable iff (!resetn)
		instr.cond == exec_pkg::branch_signed_le |-> cond_true == (flags.z || (flags.n != flags.v)))
		else $error("le condition wrong");
	jump_target_a: assert property (@(posedge clk) disable iff (!resetn)
		take_op(exec_pkg::jump_absolute) |=> pc == $past(instr.target))
		else $error("jump pc wrong");
	jump_flags_a: assert property (@(posedge clk) disable iff (!resetn)
		take_op(exec_pkg::jump_absolute) |=> $stable(flags))
		else $error("flags changed by jump");

	// ---------------------------------------------------------------
	// Stack checks
	// ---------------------------------------------------------------
	sequence stack_wait;
		mem.req && !mem_ack;
	endsequence

	sequence stack_done;
		mem.req && mem_ack;
	endsequence

	call_target_a: assert property (@(posedge clk) disable iff (!resetn)
		take && is_call |=> pc == $past(instr.target) && state == st_push)
		else $error("call target wrong");
	ret_read_a: assert property (@(posedge clk) disable iff (!resetn)
		take && is_ret |=> mem.req && !mem.we && mem.addr == sp && sp == $past(sp))
		else $error("return read wrong");
	pop_sp_a: assert property (@(posedge clk) disable iff (!resetn)
		state == st_pop && mem_ack |=> sp == $past(sp) + 24'(exec_pkg::RET_BYTES))
		else $error("pop sp wrong");
	push_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		state == st_push && mem_ack |=> sp == $past(sp) && pc == $past(pc))
		else $error("push end moved sp or pc");
	// The request must not wander while the stack side is slow
	push_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		stack_wait |=> $stable(mem) && !instr_ready)
		else $error("stack request not held");
	stall_ready_a: assert property (@(posedge clk) disable iff (!resetn)
		mem.req |-> !instr_ready)
		else $error("ready during stack access");
	ready_back_a: assert property (@(posedge clk) disable iff (!resetn)
		stack_done |=> instr_ready && !mem.req)
		else $error("ready not back after stack access");

endmodule // bit_carry_ops_and_branch_eval

`default_nettype wire

/* exec_pkg.sv */
package exec_pkg;
	// ---------------------------------------------------------------
	// Widths and codes
	// ---------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int PC_STEP = 2;
	localparam int RET_BYTES = 4;
	localparam logic [23:0] SP_RESET = 24'hfff000;
	localparam logic [23:0] PC_RESET = 24'h000000;
	localparam logic [3:0] CCR_RESET = 4'h0;

	typedef enum logic [4:0] {
		op_none,
		bit_or_carry,
		inverted_bit_or_carry,
		bit_xor_carry,
		inverted_bit_xor_carry,
		bit_load_carry,
		inverted_bit_load_carry,
		bit_store_carry,
		inverted_bit_store_carry,
		cond_branch,
		jump_absolute,
		call_relative,
		call_absolute,
		return_sub
	} op_t;

	// Branch condition field, four bits as in the condition field of a branch
	typedef enum logic [3:0] {
		branch_always,
		branch_never,
		branch_unsigned_higher,
		branch_lower_or_same,
		branch_carry_clear,
		branch_carry_set,
		branch_not_equal,
		branch_equal,
		branch_overflow_clear,
		branch_overflow_set,
		branch_plus,
		branch_minus,
		branch_signed_ge,
		branch_signed_lt,
		branch_signed_gt,
		branch_signed_le
	} cond_t;

	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} flags_t;

	typedef struct packed {
		op_t op;
		cond_t cond;
		logic [2:0] bit_no;
		logic [7:0] operand;
		logic [23:0] target;
		logic [23:0] next_pc;
	} instr_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [23:0] addr;
		logic [31:0] wdata;
	} mem_req_t;
endpackage

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ----
	// Design and stimulus
	// ----
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic instr_valid = 1'b0;
	logic mem_ack = 1'b0;
	logic [31:0] mem_rdata = 32'h0;
	exec_pkg::instr_t instr = '0;
	exec_pkg::instr_t s;
	exec_pkg::flags_t flags;
	exec_pkg::mem_req_t mem;
	logic instr_ready;
	logic result_valid;
	logic [23:0] pc;
	logic [23:0] sp;
	logic [7:0] result_byte;
	int mismatches = 0;
	int cmp_count = 0;
	int seed = 56368;
	logic mc = 1'b0;
	logic [23:0] msp = exec_pkg::SP_RESET;
	logic [23:0] ret_q[$];
	always #20 clk = ~clk;
	bit_carry_ops_and_branch_eval bit_carry_ops_and_branch_eval_i (.clk(clk), .resetn(resetn), .instr(instr),
		.instr_valid(instr_valid), .instr_ready(instr_ready), .flags(flags), .pc(pc), .sp(sp),
		.result_byte(result_byte), .result_valid(result_valid), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// ----
	// Expectations and drivers
	// ----
	function automatic logic taken(exec_pkg::cond_t k, exec_pkg::flags_t f);
		logic [15:0] t;
		t = {f.z | (f.n ^ f.v), ~(f.z | (f.n ^ f.v)), f.n ^ f.v, ~(f.n ^ f.v), f.n, ~f.n, f.v, ~f.v,
			f.z, ~f.z, f.c, ~f.c, f.c | f.z, ~(f.c | f.z), 2'b01};
		return t[k];
	endfunction
	function automatic logic nc(exec_pkg::op_t o, logic c, logic b);
		case (o)
			exec_pkg::bit_or_carry: return c | b;
			exec_pkg::inverted_bit_or_carry: return c | ~b;
			exec_pkg::bit_xor_carry: return c ^ b;
			exec_pkg::inverted_bit_xor_carry: return c ^ ~b;
			exec_pkg::bit_load_carry: return b;
			exec_pkg::inverted_bit_load_carry: return ~b;
			default: return c;
		endcase
	endfunction
	function automatic exec_pkg::instr_t rnd(exec_pkg::op_t o);
		logic [95:0] r;
		exec_pkg::instr_t x;
		r = {$random(seed), $random(seed), $random(seed)};
		x = r[67:0];
		x.op = o;
		return x;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task offer(input exec_pkg::instr_t x);
		@(posedge clk);
		instr <= x;
		instr_valid <= 1'b1;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
	endtask
	task bit_op(input exec_pkg::instr_t x);
		logic ec;
		logic st;
		logic [7:0] eb;
		logic tk;
		ec = nc(x.op, mc, x.operand[x.bit_no]);
		eb = x.operand;
		eb[x.bit_no] = (x.op == exec_pkg::inverted_bit_store_carry) ? ~mc : mc;
		st = x.op inside {exec_pkg::bit_store_carry, exec_pkg::inverted_bit_store_carry};
		tk = x.op == exec_pkg::jump_absolute || (x.op == exec_pkg::cond_branch && taken(x.cond, {3'b000, mc}));
		offer(x);
		chk(flags, {3'b000, ec});
		chk(pc, tk ? x.target : x.next_pc);
		chk(result_valid, st);
		if (st) chk(result_byte, eb);
		mc = ec;
	endtask
	task stack_op(input exec_pkg::instr_t x, input int d);
		logic [23:0] ep;
		logic cl;
		exec_pkg::instr_t rogue;
		cl = x.op != exec_pkg::return_sub;
		rogue = rnd(exec_pkg::bit_load_carry);
		rogue.operand = {8{~mc}};
		offer(x);
		if (cl) begin
			msp = msp - 24'h4;
			ret_q.push_back(x.next_pc);
			ep = x.target;
			chk(mem.wdata, {8'h00, x.next_pc});
		end else begin
			ep = ret_q.pop_back();
		end
		chk({mem.req, mem.we, mem.addr, instr_ready}, {1'b1, cl, msp, 1'b0});
		// A stray offer while the stack access is open must be refused
		@(posedge clk);
		instr <= rogue;
		instr_valid <= 1'b1;
		repeat (d) @(posedge clk);
		#1 chk(mem.req, 1'b1);
		@(posedge clk);
		instr_valid <= 1'b0;
		mem_ack <= 1'b1;
		mem_rdata <= {8'($random(seed)), ep};
		@(posedge clk);
		mem_ack <= 1'b0;
		#1;
		if (!cl) msp = msp + 24'h4;
		chk(pc, ep);
		chk(sp, msp);
		chk({mem.req, instr_ready, flags}, {2'b01, 3'b000, mc});
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#1000000;
		mismatches++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		chk({pc, flags}, {exec_pkg::PC_RESET, exec_pkg::CCR_RESET});
		chk(sp, exec_pkg::SP_RESET);
		resetn <= 1'b1;
		for (int k = 0; k < 64; k++) begin
			s = rnd(exec_pkg::op_t'(1 + k % 8));
			s.bit_no = 3'(k / 8);
			bit_op(s);
		end
		$display("test bit ops done");
		for (int k = 0; k < 34; k++) begin
			s = rnd(exec_pkg::bit_load_carry);
			s.operand = {8{k[0]}};
			bit_op(s);
			s = rnd(k < 32 ? exec_pkg::cond_branch : exec_pkg::jump_absolute);
			s.cond = exec_pkg::cond_t'(k[4:1]);
			bit_op(s);
		end
		$display("test branches done");
		stack_op(rnd(exec_pkg::call_relative), 0);
		stack_op(rnd(exec_pkg::call_absolute), 3);
		stack_op(rnd(exec_pkg::return_sub), 1);
		stack_op(rnd(exec_pkg::return_sub), 0);
		// An acknowledge with no access open is ignored
		@(posedge clk);
		mem_ack <= 1'b1;
		@(posedge clk);
		mem_ack <= 1'b0;
		#1 chk({mem.req, sp}, {1'b0, msp});
		$display("test calls done");
		// Reset in mid-run, with C set and a push still open
		s = rnd(exec_pkg::bit_load_carry);
		s.operand = 8'hff;
		bit_op(s);
		offer(rnd(exec_pkg::call_absolute));
		chk(mem.req, 1'b1);
		@(posedge clk);
		resetn <= 1'b0;
		@(posedge clk);
		#1 chk({pc, flags}, {exec_pkg::PC_RESET, exec_pkg::CCR_RESET});
		chk({sp, result_valid, mem.req, instr_ready}, {exec_pkg::SP_RESET, 3'b001});
		@(posedge clk);
		resetn <= 1'b1;
		mc = 1'b0;
		msp = exec_pkg::SP_RESET;
		$display("test mid-run reset done");
		for (int k = 0; k < 200; k++) bit_op(rnd(exec_pkg::op_t'(1 + $unsigned($random(seed)) % 10)));
		$display("test random mix done");
		stop_test();
	end
endmodule // testbench
`default_nettype wire
